// ==== rtdr_adc_model.sv ====
// Behavioural pair of converters that answer the readout's start pulses.
`timescale 1ns/10ps
`default_nettype none

module rtdr_adc_model
  import rtdr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [MODULES-1:0] adc_start,
  input wire logic [MODULES*2-1:0] adc_chan,
  output logic [MODULES-1:0] adc_done,
  output logic [MODULES*RESULT_W-1:0] adc_result
);
  int cnt [MODULES];
  int d;
  int idx;
  logic [RESULT_W-1:0] v;

  // Each converter waits a short or a long time, shows its result, then
  // raises done for two cycles. The long wait still ends inside the slot.
  // Once done falls the result lines carry the inverse, as a released bus.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adc_done <= '0;
      adc_result <= '0;
      for (int m = 0; m < MODULES; m++) cnt[m] = 0;
    end else begin
      d = slow ? 9 : 1;
      for (int m = 0; m < MODULES; m++) begin
        idx = m * 4 + int'(adc_chan[m*2+:2]);
        v = (idx == 0) ? 12'h000 : (idx == 7) ? 12'hfff :
            12'(idx * 256 + (slow ? 90 : 165));
        if (adc_start[m]) begin
          cnt[m] = 1;
        end else if (cnt[m] > 0) begin
          cnt[m]++;
        end
        if (cnt[m] == d) begin
          adc_result[m*RESULT_W+:RESULT_W] <= v;
        end
        if (cnt[m] == d + 1) begin
          adc_done[m] <= 1'b1;
        end
        if (cnt[m] == d + 3) begin
          adc_done[m] <= 1'b0;
          adc_result[m*RESULT_W+:RESULT_W] <= ~v;
          cnt[m] = 0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== rtdr_pkg.sv ====
// Shared constants for the resistance-thermometer input bus readout.
package rtdr_pkg;

  // ****************************************************************
  // Bus address decode
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int TOP_MSB = 15;
  localparam int TOP_LSB = 13;
  localparam logic [2:0] TOP_FIXED = 3'h7;
  localparam int UNIT_MSB = 12;
  localparam int UNIT_LSB = 8;
  localparam int UNIT_W = 5;
  localparam int CHAN_MSB = 4;
  localparam int CHAN_LSB = 3;
  localparam int MODSEL_MSB = 2;
  localparam logic [2:0] MODSEL_FIRST = 3'h0;
  localparam logic [2:0] MODSEL_SECOND = 3'h4;
  localparam logic [7:0] PAGE_LOWEST = 8'he0;

  // Register map for the example unit setting.
  localparam logic [15:0] MOD0_CH1_TEMPERATURE = 16'he800;
  localparam logic [15:0] MOD2_CH1_TEMPERATURE = 16'he804;
  localparam logic [15:0] MOD0_CH2_TEMPERATURE = 16'he808;
  localparam logic [15:0] MOD2_CH2_TEMPERATURE = 16'he80c;
  localparam logic [15:0] MOD0_CH3_TEMPERATURE = 16'he810;
  localparam logic [15:0] MOD2_CH3_TEMPERATURE = 16'he814;
  localparam logic [15:0] MOD0_CH4_TEMPERATURE = 16'he818;
  localparam logic [15:0] MOD2_CH4_TEMPERATURE = 16'he81c;

  // ****************************************************************
  // Read word layout
  // ****************************************************************
  localparam int DATA_W = 16;
  localparam int RESULT_W = 12;
  localparam int RESULT_LSB = 3;
  localparam int RESULT_MSB = 14;
  localparam logic [15:0] FULL_SCALE_WORD = 16'h7ff8;
  localparam int SPAN_DEG_C = 450;
  localparam int SPAN_COUNTS = 32768;

  // ****************************************************************
  // Channels and timing
  // ****************************************************************
  localparam int CH_PER_MODULE = 4;
  localparam int MODULES = 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 40000;
  localparam int REFRESH_TIME_NS = 160000;
  // Longest time, so rounded down to whole cycles.
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam longint REF_CLK_HZ = 64'd20000000;
  localparam longint CONV_CLK_HZ = 64'd2457600;
  localparam int PHASE_W = 16;
  localparam longint CONV_PHASE_INC =
    (CONV_CLK_HZ * (64'd1 << PHASE_W)) / REF_CLK_HZ;

endpackage

// ==== rtdr_readout.sv ====
// Backplane read slave for two four-channel temperature modules.
`timescale 1ns/10ps
`default_nettype none

module rtdr_readout
  import rtdr_pkg::*;
#(
  parameter int SLOT_CYCLES = CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_rd_n,
  input wire logic [UNIT_W-1:0] unit_address_jumpers,
  input wire logic [MODULES-1:0] module_layout_jumpers,
  input wire logic [MODULES-1:0] adc_done,
  input wire logic [MODULES*RESULT_W-1:0] adc_result,
  output logic [MODULES-1:0] adc_start,
  output logic [MODULES*2-1:0] adc_chan,
  output logic conv_clk,
  output logic [DATA_W-1:0] bus_data_out,
  output logic bus_data_oe
);

  localparam int VAL_W = CH_PER_MODULE * RESULT_W;

  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic rd_s1, rd_s2;
  logic [UNIT_W-1:0] jmp_s1, jmp_s2;
  logic [MODULES-1:0] fit_s1, fit_s2;
  logic [MODULES*VAL_W-1:0] values;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W-1:0] next_phase;
  logic next_conv_clk;
  logic hit;
  logic mod_sel;
  logic [1:0] chan_sel;
  logic [RESULT_W-1:0] picked;
  logic [DATA_W-1:0] next_data;
  logic next_oe;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Bus pins and jumpers are asynchronous to ref_clk.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_s1 <= '0;
      addr_s2 <= '0;
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      jmp_s1 <= '0;
      jmp_s2 <= '0;
      fit_s1 <= '0;
      fit_s2 <= '0;
    end else begin
      addr_s1 <= bus_addr;
      addr_s2 <= addr_s1;
      rd_s1 <= !bus_rd_n;
      rd_s2 <= rd_s1;
      jmp_s1 <= unit_address_jumpers;
      jmp_s2 <= jmp_s1;
      fit_s1 <= module_layout_jumpers;
      fit_s2 <= fit_s1;
    end
  end

  // ****************************************************************
  // Conversion sequencers, one per module position
  // ****************************************************************

  genvar m;
  generate
    for (m = 0; m < MODULES; m++) begin : g_mod
      rtdr_scan #(
        .CHANNELS(CH_PER_MODULE),
        .SLOT_CYCLES(SLOT_CYCLES)
      ) u_scan (
        .ref_clk(ref_clk),
        .rst(rst),
        .adc_done(adc_done[m]),
        .adc_result(adc_result[m*RESULT_W +: RESULT_W]),
        .adc_start(adc_start[m]),
        .adc_chan(adc_chan[m*2 +: 2]),
        .values(values[m*VAL_W +: VAL_W])
      );
    end
  endgenerate

  // ****************************************************************
  // Conversion clock
  // ****************************************************************

  // A phase accumulator gives the mean rate to within its truncated step; the cost is up to
  // one ref_clk period of jitter on each edge, which the converters
  // tolerate since they only count edges.
  always_comb begin
    next_phase = phase + PHASE_W'(CONV_PHASE_INC);
    next_conv_clk = phase[PHASE_W-1];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
      conv_clk <= 1'b0;
    end else begin
      phase <= next_phase;
      conv_clk <= next_conv_clk;
    end
  end

  // ****************************************************************
  // Address decode and read answer
  // ****************************************************************

  // Bits 7..5 take no part in the decode, so every alias answers.
  always_comb begin
    mod_sel = addr_s2[MODSEL_MSB];
    chan_sel = addr_s2[CHAN_MSB:CHAN_LSB];
    hit = (addr_s2[TOP_MSB:TOP_LSB] == TOP_FIXED)
      && (addr_s2[UNIT_MSB:UNIT_LSB] == jmp_s2)
      && ((addr_s2[MODSEL_MSB:0] == MODSEL_FIRST)
        || (addr_s2[MODSEL_MSB:0] == MODSEL_SECOND))
      && fit_s2[mod_sel];
    picked = values[{mod_sel, chan_sel}*RESULT_W +: RESULT_W];
  end

  // The converter already delivers the linear scale; the word only places
  // it so that full scale lands on the top code with the low bits clear.
  always_comb begin
    next_oe = rd_s2 && hit;
    next_data = '0;
    if (next_oe) begin
      next_data[RESULT_MSB:RESULT_LSB] = picked;
    end
  end

  // Data is only driven for a read that hits, three cycles behind the strobe pin, never else.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_data_out <= '0;
      bus_data_oe <= 1'b0;
    end else begin
      bus_data_out <= next_data;
      bus_data_oe <= next_oe;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_read_hit;
    rd_s2 && hit;
  endsequence

  chk_slave_only: assert property (
    !$past(rd_s2) |-> !bus_data_oe)
    else $error("data driven without a read");

  chk_answer_word: assert property (
    s_read_hit |=> bus_data_oe && bus_data_out[RESULT_MSB:RESULT_LSB]
      == $past(picked))
    else $error("addressed value not presented");

  chk_zero_bits: assert property (
    bus_data_oe |-> !bus_data_out[DATA_W-1]
      && bus_data_out[RESULT_LSB-1:0] == '0)
    else $error("reserved data bits not zero");

  chk_fixed_top: assert property (
    bus_data_oe |-> $past(addr_s2[TOP_MSB:TOP_LSB]) == TOP_FIXED)
    else $error("answered with upper bits not all one");

  chk_jumper_match: assert property (
    bus_data_oe |-> $past(addr_s2[UNIT_MSB:UNIT_LSB]) == $past(jmp_s2))
    else $error("answered outside jumper page");

  chk_module_code: assert property (
    bus_data_oe |-> $past(addr_s2[1:0]) == 2'h0)
    else $error("answered an illegal module code");

  chk_page_range: assert property (
    bus_data_oe |-> $past(addr_s2[TOP_MSB:UNIT_LSB]) >= PAGE_LOWEST)
    else $error("answered below the unit page range");

  chk_miss_silent: assert property (
    rd_s2 && !hit |=> !bus_data_oe)
    else $error("foreign address answered");

  chk_conv_toggle: assert property (
    $rose(conv_clk) |-> ##[1:8] $fell(conv_clk))
    else $error("conversion clock stalled");

  chk_idle_zero: assert property (
    !bus_data_oe |-> bus_data_out == '0)
    else $error("data lines not zero while idle");

  chk_unfitted_quiet: assert property (
    rd_s2 && !fit_s2[addr_s2[MODSEL_MSB]] |=> !bus_data_oe)
    else $error("empty module position answered");

  // A strobe that has just gone away must take the data lines with it,
  // or two slaves could fight over the bus on the next access.
  sequence s_strobe_gone;
    rd_s2 ##1 !rd_s2;
  endsequence

  chk_release_quiet: assert property (
    s_strobe_gone |=> !bus_data_oe)
    else $error("data still driven after the strobe ended");

  // ****************************************************************
  // Conversion clock run length
  // ****************************************************************

  // Longest stay of conv_clk at one level: half the accumulator range
  // over the step, rounded up, plus the extra low cycle that the output
  // register adds right after reset.
  localparam int CONV_HALF_MAX =
    int'(((64'd1 << (PHASE_W - 1)) + CONV_PHASE_INC - 1) / CONV_PHASE_INC)
    + 1;

  int conv_run;
  int next_conv_run;
  logic conv_last;
  logic next_conv_last;

  // Counts the cycles that conv_clk has held its present level; a stuck
  // accumulator would let this grow without bound.
  always_comb begin
    next_conv_last = conv_clk;
    next_conv_run = (conv_clk == conv_last) ? conv_run + 1 : 1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_run <= 0;
      conv_last <= 1'b0;
    end else begin
      conv_run <= next_conv_run;
      conv_last <= next_conv_last;
    end
  end

  chk_conv_halves: assert property (
    conv_run <= CONV_HALF_MAX)
    else $error("conversion clock level held too long");

  // ****************************************************************
  // Refresh order per module
  // ****************************************************************

  // One lap is four slots, channel 0 through channel 3, so channel 0
  // must come back after exactly four slot lengths.
  localparam int REFRESH_CYCLES = CH_PER_MODULE * SLOT_CYCLES;

  genvar r;
  generate
    for (r = 0; r < MODULES; r++) begin : g_refresh
      int lap;
      int next_lap;
      logic lap_seen;
      logic next_lap_seen;
      logic lap_mark;

      // A start pulse for channel 0 opens a new lap.
      always_comb begin
        lap_mark = adc_start[r] && adc_chan[r*2 +: 2] == 2'h0;
        next_lap = lap_mark ? 0 : lap + 1;
        next_lap_seen = lap_seen || lap_mark;
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          lap <= 0;
          lap_seen <= 1'b0;
        end else begin
          lap <= next_lap;
          lap_seen <= next_lap_seen;
        end
      end

      chk_refresh_lap: assert property (
        @(posedge ref_clk) disable iff (rst)
        lap_mark && lap_seen |-> lap == REFRESH_CYCLES - 1)
        else $error("module refresh period wrong");

      chk_chan_steady: assert property (
        @(posedge ref_clk) disable iff (rst)
        !adc_start[r] |-> $stable(adc_chan[r*2 +: 2]))
        else $error("channel index moved inside a slot");
    end
  endgenerate

endmodule

`default_nettype wire

// ==== rtdr_scan.sv ====
// Conversion sequencer for one four-channel sensor module.
`timescale 1ns/10ps
`default_nettype none

module rtdr_scan
  import rtdr_pkg::*;
#(
  parameter int CHANNELS = CH_PER_MODULE,
  parameter int SLOT_CYCLES = CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic adc_done,
  input wire logic [RESULT_W-1:0] adc_result,
  output logic adc_start,
  output logic [1:0] adc_chan,
  output logic [CHANNELS*RESULT_W-1:0] values
);

  typedef enum logic {SC_LAUNCH, SC_CONVERT} rtdr_scan_t;

  rtdr_scan_t state;
  rtdr_scan_t next_state;
  logic [$clog2(SLOT_CYCLES)-1:0] slot;
  logic [$clog2(SLOT_CYCLES)-1:0] next_slot;
  logic [1:0] next_chan;
  logic next_start;
  logic done_s1, done_s2, done_s3;
  logic [RESULT_W-1:0] res_s1, res_s2;
  logic [RESULT_W-1:0] store [CHANNELS];
  logic done_edge;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // The converter's strobe and result come from another domain.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      res_s1 <= '0;
      res_s2 <= '0;
    end else begin
      done_s1 <= adc_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      res_s1 <= adc_result;
      res_s2 <= res_s1;
    end
  end

  // Result data settles one cycle before done rises, so two stages suffice.
  assign done_edge = done_s2 && !done_s3;

  // ****************************************************************
  // Slot sequencer
  // ****************************************************************

  // Each channel owns one fixed slot; four slots give one full refresh.
  always_comb begin
    next_state = state;
    next_slot = slot;
    next_chan = adc_chan;
    next_start = 1'b0;
    unique case (state)
      SC_LAUNCH: begin
        next_state = SC_CONVERT;
        next_slot = slot + 1'b1;
      end
      SC_CONVERT: begin
        if (slot == ($clog2(SLOT_CYCLES))'(SLOT_CYCLES - 1)) begin
          next_state = SC_LAUNCH;
          next_slot = '0;
          next_start = 1'b1;
          next_chan = adc_chan + 1'b1;
        end else begin
          next_slot = slot + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SC_CONVERT;
      slot <= '0;
      adc_chan <= 2'h3;
      adc_start <= 1'b0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      adc_chan <= next_chan;
      adc_start <= next_start;
    end
  end

  // A late result is written into the next channel's entry, or dropped if its edge falls in the launch cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        store[i] <= '0;
      end
    end else if (done_edge && state == SC_CONVERT) begin
      store[adc_chan] <= res_s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_out
      assign values[g*RESULT_W +: RESULT_W] = store[g];
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************

  int gap;
  logic seen;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap <= 0;
      seen <= 1'b0;
    end else begin
      gap <= adc_start ? 0 : gap + 1;
      seen <= seen | adc_start;
    end
  end

  chk_slot_spacing: assert property (
    @(posedge ref_clk) disable iff (rst)
    adc_start && seen |-> gap == SLOT_CYCLES - 1)
    else $error("conversion slot length wrong");

  chk_channel_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(adc_start) |-> adc_chan == 2'($past(adc_chan) + 1'b1))
    else $error("channel did not advance by one");

endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the temperature readout bus slave.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import rtdr_pkg::*;
  typedef struct {logic [15:0] a; logic [15:0] e; bit hit;} rtdr_row_t;
  logic ref_clk, rst, bus_rd_n, slow, conv_clk, bus_data_oe;
  logic [15:0] bus_addr, bus_data_out;
  logic [4:0] jump;
  logic [1:0] layout, adc_done, adc_start;
  logic [3:0] adc_chan;
  logic [23:0] adc_result;
  int mismatches, num_checks, cyc, n;
  logic [1:0] ch;
  rtdr_row_t r;
  rtdr_row_t rows [14] = '{
    '{16'he800, 16'h0000, 1}, '{16'he808, 16'h0d28, 1},
    '{16'he810, 16'h1528, 1}, '{16'he818, 16'h1d28, 1},
    '{16'he804, 16'h2528, 1}, '{16'he80c, 16'h2d28, 1},
    '{16'he814, 16'h3528, 1}, '{16'he81c, 16'h7ff8, 1},
    '{16'he8ec, 16'h2d28, 1}, '{16'h6800, 16'h0000, 0},
    '{16'he900, 16'h0000, 0}, '{16'he801, 16'h0000, 0},
    '{16'he802, 16'h0000, 0}, '{16'he806, 16'h0000, 0}};

  rtdr_readout #(.SLOT_CYCLES(16)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .bus_addr(bus_addr), .bus_rd_n(bus_rd_n),
    .unit_address_jumpers(jump), .module_layout_jumpers(layout),
    .adc_done(adc_done), .adc_result(adc_result), .adc_start(adc_start),
    .adc_chan(adc_chan), .conv_clk(conv_clk),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));
  rtdr_adc_model i_adc (.ref_clk(ref_clk), .rst(rst), .slow(slow),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_result(adc_result));

  // Free-running 20 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Watchdog; the whole run needs well under a tenth of this ceiling.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_word({15'h0, g}, {15'h0, e});
  endtask

  // One read cycle; the strobe stays low until the answer or a time limit.
  task automatic rd(input logic [15:0] a, input logic [15:0] e, bit hit);
    int k;
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd_n = 1'b0;
    k = 0;
    while (bus_data_oe !== 1'b1 && k < 6) begin
      @(negedge ref_clk);
      k++;
    end
    chk_bit(bus_data_oe, hit);
    chk_word(bus_data_out, e);
    bus_rd_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_bit(bus_data_oe, 1'b0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    bus_rd_n = 1'b1;
    bus_addr = 16'h0000;
    jump = 5'h08;
    layout = 2'b11;
    slow = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_word({12'h0, adc_chan}, 16'h000f);
    rst = 1'b0;
    rd(16'he81c, 16'h0000, 1'b1);
    $display("test power-up done");
    repeat (90) @(negedge ref_clk);
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      rd(r.a, r.e, r.hit);
    end
    $display("test table done");
    // Start spacing and channel order; the slot is shortened to 16 cycles.
    n = 0;
    while (adc_start[0] !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    ch = adc_chan[1:0];
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (adc_start[0] !== 1'b1 && n < 40);
    chk_word(16'(n), 16'h0010);
    chk_word({14'h0, adc_chan[1:0]}, {14'h0, ch + 2'h1});
    $display("test slot done");
    // Roughly 122.88 rising edges expected in 1000 cycles.
    n = 0;
    for (int i = 0; i < 1000; i++) begin
      ch[0] = conv_clk;
      @(negedge ref_clk);
      if (!ch[0] && conv_clk) n++;
    end
    chk_bit(n >= 121 && n <= 124, 1'b1);
    $display("test clock done");
    slow = 1'b1;
    repeat (100) @(negedge ref_clk);
    rd(16'he808, 16'h0ad0, 1'b1);
    rd(16'he80c, 16'h2ad0, 1'b1);
    slow = 1'b0;
    $display("test slow done");
    layout = 2'b01;
    rd(16'he804, 16'h0000, 1'b0);
    layout = 2'b11;
    jump = 5'h1f;
    rd(16'hff1c, 16'h7ff8, 1'b1);
    rd(16'he81c, 16'h0000, 1'b0);
    jump = 5'h00;
    rd(16'he01c, 16'h7ff8, 1'b1);
    jump = 5'h08;
    $display("test jumpers done");
    // Reset in mid-run clears the stored values and the bus, clock and start outputs, and sets adc_chan to 3.
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_word({bus_data_out}, 16'h0000);
    chk_word({12'h0, adc_chan}, 16'h000f);
    chk_bit(bus_data_oe | conv_clk | (|adc_start), 1'b0);
    rst = 1'b0;
    rd(16'he81c, 16'h0000, 1'b1);
    $display("test reset done");
    results();
  end
endmodule

`default_nettype wire
